// *** hw/csf_ctrl.sv ***
// Combined serial frame controller: deserial and SPI frame scheduler,
// serial shifter, halt handling and transfer-complete request.
// Assumes control bits come from same-clock logic; sdi is asynchronous.
`timescale 1ns/1ps
module csf_ctrl #(
    parameter int DAT_CYC    = csf_pkg::DAT_CYC,
    parameter int SCK_HALF   = csf_pkg::SCK_HALF,
    parameter int DSI_PERIOD = csf_pkg::DSI_PERIOD
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Configuration and control
    input  wire csf_pkg::csf_mode_t          mode,
    input  wire logic                        halt_req,
    input  wire logic                        transfer_complete_req_enable,
    input  wire logic                        tcf_clr,
    input  wire logic                        corrupt_clr,
    input  wire logic [csf_pkg::FRAME_BITS-1:0] dsi_data,
    // Transmit push register
    input  wire logic                        push_valid,
    input  wire csf_pkg::csf_push_t          push_in,
    output logic                             push_ready,
    // Status
    output logic                             txrx_running_status,
    output logic                             transfer_complete_flag,
    output logic                             tcf_irq,
    output logic                             corrupt_seen,
    output logic [csf_pkg::FRAME_BITS-1:0]   rx_data,
    output logic [csf_pkg::CMD_BITS-1:0]     frame_cmd,
    // Serial pins
    output logic                             sck_o,
    output logic                             sdo_o,
    output logic                             cs_n_o,
    input  wire logic                        sdi_i
);

    localparam int FB  = csf_pkg::FRAME_BITS;
    localparam int HW  = $clog2(SCK_HALF + 1);
    localparam int DW  = $clog2(DAT_CYC + 1);
    localparam int PW  = $clog2(DSI_PERIOD + 1);
    localparam int BW  = $clog2(FB + 1);
    localparam logic [HW-1:0] HALF_LAST = HW'(SCK_HALF - 1);
    localparam logic [DW-1:0] DAT_LAST  = DW'(DAT_CYC - 1);
    localparam logic [DW-1:0] HAZ_FIRST = DW'(DAT_CYC - csf_pkg::HAZARD_CYC);
    localparam logic [PW-1:0] PER_LAST  = PW'(DSI_PERIOD - 1);

    csf_pkg::csf_state_t    state_ff, nxt_state;
    csf_pkg::csf_push_t     pend_ff;
    logic                   pend_vld_ff, pend_bad_ff, dsi_due_ff;
    logic                   tcf_ff, corrupt_ff, sck_ff, cs_n_ff, bad_ff;
    logic [FB-1:0]          sh_ff, rx_ff;
    logic [csf_pkg::CMD_BITS-1:0] cmd_ff;
    logic [HW-1:0]          half_ff;
    logic [DW-1:0]          dat_ff;
    logic [PW-1:0]          per_ff;
    logic [BW-1:0]          bit_ff;
    logic                   sdi_m_ff, sdi_s_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire logic is_idle    = (state_ff == csf_pkg::CSF_IDLE);
    wire logic is_shift   = (state_ff == csf_pkg::CSF_SHIFT);
    wire logic is_dat     = (state_ff == csf_pkg::CSF_DAT);
    wire logic spi_ok     = (mode != csf_pkg::CSF_DSI_ONLY);
    wire logic dsi_ok     = (mode != csf_pkg::CSF_SPI_ONLY);
    wire logic push_take  = push_valid && push_ready;
    // Combined mode only: single-mode operation has no interleave hazard
    wire logic hazard     = is_dat && (dat_ff >= HAZ_FIRST)
                            && (mode == csf_pkg::CSF_COMBINED);
    wire logic start_spi  = is_idle && !halt_req && pend_vld_ff && spi_ok;
    wire logic start_dsi  = is_idle && !halt_req && !start_spi
                            && dsi_due_ff && dsi_ok;
    wire logic half_end   = is_shift && (half_ff == HALF_LAST);
    wire logic rise       = half_end && !sck_ff;
    wire logic fall       = half_end && sck_ff;
    // A corrupted frame is one bit short: the framing is wrong
    wire logic [BW-1:0] nbits = bad_ff ? BW'(FB - 1) : BW'(FB);
    wire logic frame_end  = fall && (bit_ff + BW'(1) == nbits);
    wire logic dat_end    = is_dat && (dat_ff == DAT_LAST);

    assign push_ready             = !pend_vld_ff && spi_ok;
    assign txrx_running_status    = (state_ff != csf_pkg::CSF_HALTED);
    assign transfer_complete_flag = tcf_ff;
    assign tcf_irq                = tcf_ff && transfer_complete_req_enable;
    assign corrupt_seen           = corrupt_ff;
    assign rx_data                = rx_ff;
    assign frame_cmd              = cmd_ff;
    assign sck_o                  = sck_ff;
    assign sdo_o                  = sh_ff[FB-1];
    assign cs_n_o                 = cs_n_ff;

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer; halt is honoured only between frames so that the
    // frame in flight and its delay phase always finish
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            csf_pkg::CSF_IDLE: begin
                if (halt_req) begin
                    nxt_state = csf_pkg::CSF_HALTED;
                end else if (start_spi || start_dsi) begin
                    nxt_state = csf_pkg::CSF_SHIFT;
                end
            end
            csf_pkg::CSF_SHIFT: begin
                if (frame_end) begin
                    nxt_state = csf_pkg::CSF_DAT;
                end
            end
            csf_pkg::CSF_DAT: begin
                if (dat_end) begin
                    nxt_state = csf_pkg::CSF_IDLE;
                end
            end
            csf_pkg::CSF_HALTED: begin
                if (!halt_req) begin
                    nxt_state = csf_pkg::CSF_IDLE;
                end
            end
            default: nxt_state = csf_pkg::CSF_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= csf_pkg::CSF_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser for the serial data pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdi_m_ff <= 1'b0;
            sdi_s_ff <= 1'b0;
        end else begin
            sdi_m_ff <= sdi_i;
            sdi_s_ff <= sdi_m_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Single-entry push slot; hazard marks the queued frame bad
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_ff     <= '0;
            pend_vld_ff <= 1'b0;
            pend_bad_ff <= 1'b0;
        end else if (push_take) begin
            pend_ff     <= push_in;
            pend_vld_ff <= 1'b1;
            pend_bad_ff <= hazard;
        end else if (start_spi) begin
            pend_vld_ff <= 1'b0;
            pend_bad_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deserial period timer; a due frame waits out a halt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            per_ff     <= '0;
            dsi_due_ff <= 1'b0;
        end else begin
            per_ff     <= (per_ff == PER_LAST) ? '0 : per_ff + PW'(1);
            dsi_due_ff <= (per_ff == PER_LAST) || (dsi_due_ff && !start_dsi);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial shifter: mode 0, sample on rising edge, shift on falling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh_ff   <= '0;
            rx_ff   <= '0;
            cmd_ff  <= '0;
            bad_ff  <= 1'b0;
            half_ff <= '0;
            bit_ff  <= '0;
            sck_ff  <= csf_pkg::SCK_IDLE;
            cs_n_ff <= csf_pkg::CS_IDLE_N;
        end else if (start_spi || start_dsi) begin
            sh_ff   <= start_spi ? pend_ff.data : dsi_data;
            cmd_ff  <= start_spi ? pend_ff.cmd : '0;
            bad_ff  <= start_spi && pend_bad_ff;
            half_ff <= '0;
            bit_ff  <= '0;
            cs_n_ff <= 1'b0;
        end else if (is_shift) begin
            half_ff <= half_end ? '0 : half_ff + HW'(1);
            if (half_end) begin
                sck_ff <= !sck_ff;
            end
            if (rise) begin
                rx_ff <= {rx_ff[FB-2:0], sdi_s_ff};
            end
            if (fall) begin
                sh_ff  <= {sh_ff[FB-2:0], 1'b0};
                bit_ff <= bit_ff + BW'(1);
            end
            if (frame_end) begin
                cs_n_ff <= csf_pkg::CS_IDLE_N;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay-after-transfer counter
    always_ff @(posedge clk) begin
        if (!rst_n || !is_dat) begin
            dat_ff <= '0;
        end else begin
            dat_ff <= dat_ff + DW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the clear cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tcf_ff     <= 1'b0;
            corrupt_ff <= 1'b0;
        end else begin
            tcf_ff     <= frame_end || (tcf_ff && !tcf_clr);
            corrupt_ff <= (push_take && hazard) || (corrupt_ff && !corrupt_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    tcf_set_a: assert property (frame_end |=> tcf_ff)
        else $error("frame ended without transfer-complete");
    tcf_hold_a: assert property (tcf_ff && !tcf_clr |=> tcf_ff)
        else $error("transfer-complete lost without clear");
    irq_gate_a: assert property (frame_end |=> tcf_irq == transfer_complete_req_enable)
        else $error("request does not follow flag and enable");
    halt_entry_a: assert property (
        $rose(state_ff == csf_pkg::CSF_HALTED) |-> $past(is_idle) && $past(halt_req))
        else $error("halt entered mid frame");
    halt_stat_a: assert property (is_shift && halt_req |-> ##1 txrx_running_status)
        else $error("status dropped during a frame");
    hazard_mark_a: assert property (push_take && hazard |=> pend_bad_ff && corrupt_ff)
        else $error("hazard push not marked");
    clean_push_a: assert property (push_take && !hazard |=> !pend_bad_ff)
        else $error("clean push marked bad");
    dsi_only_a: assert property (mode == csf_pkg::CSF_DSI_ONLY |-> !push_ready)
        else $error("push accepted in deserial-only mode");
    dsi_start_a: assert property (start_dsi |=> is_shift && !cs_n_o)
        else $error("due deserial frame not started");
    dat_span_a: assert property ($rose(is_dat) |-> is_dat[*2])
        else $error("delay phase too short");

    halt_seen_c:   cover property ($rose(state_ff == csf_pkg::CSF_HALTED));
    bad_push_c:    cover property (push_take && hazard);
    spi_frame_c:   cover property (start_spi ##[1:400] frame_end);
    dsi_frame_c:   cover property (start_dsi);

endmodule : csf_ctrl

// *** inc/csf_pkg.sv ***
// Shared constants and types of the combined serial frame controller.
// Assumes one 125 MHz peripheral clock and a synchronous active-low reset.
//
// Overview of operation
// - Combined mode sends periodic deserial frames and interleaves pushed SPI frames.
// - In combined mode, a push in the last two cycles of delay-after-transfer corrupts the frame.
// - Running status drops once halted and any frame in flight has ended.
// - Transfer-complete flag raises the request when its enable is set.
package csf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_NS       = 8;
    localparam int DAT_NS       = 64;    // Delay-after-transfer, least time
    localparam int DAT_CYC      = (DAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int HAZARD_CYC   = 2;     // Tail of the delay phase at risk
    localparam int SCK_HALF     = 4;     // Clock cycles per serial half period
    localparam int DSI_PERIOD   = 256;   // Cycles between deserial frames
    localparam int FRAME_BITS   = 16;
    localparam int CMD_BITS     = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic       SCK_IDLE  = 1'b0;
    localparam logic       CS_IDLE_N = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Modes and states
    typedef enum logic [1:0] {
        CSF_COMBINED,
        CSF_DSI_ONLY,
        CSF_SPI_ONLY
    } csf_mode_t;

    typedef enum logic [2:0] {
        CSF_IDLE,
        CSF_SHIFT,
        CSF_DAT,
        CSF_HALTED
    } csf_state_t;

    // One entry of the transmit push register
    typedef struct packed {
        logic [CMD_BITS-1:0]   cmd;
        logic [FRAME_BITS-1:0] data;
    } csf_push_t;

endpackage : csf_pkg

// *** testbench/csf_slave_model.sv ***
// Serial peripheral on the far side of the frame controller.
// Assumes mode 0 framing: sampled on sck rise, changed on sck fall.
`timescale 1ns/1ps
module csf_slave_model (
    // Clock and serial pins
    input  wire logic        clk,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdo,
    output logic             sdi,
    // Reply word and what arrived
    input  wire logic [15:0] reply,
    output logic [15:0]      got,
    output int               bits
);
    logic [15:0] sh;
    initial sdi = 1'b0;
    // First bit must be ready before the first rise
    always @(negedge cs_n) begin
        got  = 16'h0000;
        bits = 0;
        sh   = reply;
        sdi  = reply[15];
    end
    // Capture on rise; every pulse counted, so short frames show
    always @(posedge sck) if (!cs_n) begin
        got  = {got[14:0], sdo};
        bits = bits + 1;
    end
    // Next bit on fall
    always @(negedge sck) if (!cs_n) begin
        sh  = {sh[14:0], 1'b0};
        sdi = sh[15];
    end
    // Released line has no pull: keep it moving so stale bits never pass
    always @(posedge clk) if (cs_n) sdi <= ~sdi;
endmodule : csf_slave_model

// *** testbench/test_combined_serial_frame_control.sv ***
// Self-checking bench of the combined serial frame controller.
// Assumes the peripheral model on the pins; software side is driven here.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module test_combined_serial_frame_control;
    localparam int DAT     = 8;
    localparam int HALF    = 4;
    localparam int DSI_GAP = 16384;  // One deserial frame, clear of the sweep
    ////////////////////////////////////////////////////////////////////////////
    logic               clk         = 1'b0;
    logic               rst_n       = 1'b0;
    csf_pkg::csf_mode_t mode        = csf_pkg::CSF_COMBINED;
    logic               halt_req    = 1'b0;
    logic               transfer_complete_req_enable      = 1'b0;
    logic               tcf_clr     = 1'b0;
    logic               corrupt_clr = 1'b0;
    logic [15:0]        dsi_data    = 16'hc3a5;
    logic               push_valid  = 1'b0;
    csf_pkg::csf_push_t push_in     = '0;
    logic [15:0]        reply       = 16'h0000;
    logic [31:0]        seed        = 32'h0000_ad83;
    logic               push_ready, txrx_running_status, transfer_complete_flag;
    logic               tcf_irq, corrupt_seen, sck_o, sdo_o, cs_n_o, sdi_i;
    logic [15:0]        rx_data, got;
    logic [7:0]         frame_cmd;
    csf_pkg::csf_push_t pv;
    logic               bad;
    int                 bits, hits, n;
    int                 bad_count   = 0;
    int                 comparisons = 0;
    ////////////////////////////////////////////////////////////////////////////
    csf_ctrl #(.DAT_CYC(DAT), .SCK_HALF(HALF), .DSI_PERIOD(DSI_GAP)) csf_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .mode(mode), .halt_req(halt_req), .transfer_complete_req_enable(transfer_complete_req_enable),
        .tcf_clr(tcf_clr), .corrupt_clr(corrupt_clr), .dsi_data(dsi_data),
        .push_valid(push_valid), .push_in(push_in), .push_ready(push_ready),
        .txrx_running_status(txrx_running_status),
        .transfer_complete_flag(transfer_complete_flag), .tcf_irq(tcf_irq),
        .corrupt_seen(corrupt_seen), .rx_data(rx_data), .frame_cmd(frame_cmd),
        .sck_o(sck_o), .sdo_o(sdo_o), .cs_n_o(cs_n_o), .sdi_i(sdi_i));
    csf_slave_model csf_slave_model_inst (.clk(clk), .sck(sck_o), .cs_n(cs_n_o),
        .sdo(sdo_o), .sdi(sdi_i), .reply(reply), .got(got), .bits(bits));
    // 125 MHz clock
    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // A push in the delay tail costs one clock pulse
    function automatic int exp_bits(input logic bad);
        return bad ? 15 : 16;
    endfunction : exp_bits
    // Only combined mode is exposed, and only in the tail of the delay phase
    function automatic logic exp_bad(input int m, input int k);
        return (m == 0) && (k >= DAT - csf_pkg::HAZARD_CYC) && (k < DAT);
    endfunction : exp_bad
    // Inputs move 1 ns after the edge, never on it
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_cs(input logic lvl);
        int w;
        w = 0;
        while (cs_n_o !== lvl && w < 20000) begin
            tick(1);
            w++;
        end
        `CHK(cs_n_o, lvl)
    endtask : wait_cs
    // Strobe held until an edge sees ready high
    task automatic push(input csf_pkg::csf_push_t v);
        int w;
        w = 0;
        push_valid = 1'b1;
        push_in    = v;
        while (push_ready !== 1'b1 && w < 500) begin
            tick(1);
            w++;
        end
        tick(1);
        push_valid = 1'b0;
    endtask : push
    task automatic print_verdict();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(8);
        rst_n = 1'b1;
        tick(1);
        `CHK({sck_o, cs_n_o}, 2'b01)
        `CHK({transfer_complete_flag, txrx_running_status, push_ready}, 3'b011)
        reply = 16'(rnd());
        wait_cs(1'b0);
        `CHK(frame_cmd, 8'h00)
        wait_cs(1'b1);
        tick(2);
        `CHK({got, rx_data, transfer_complete_flag}, {dsi_data, reply, 1'b1})
        transfer_complete_req_enable = 1'b1;
        tick(1);
        `CHK(tcf_irq, 1'b1)
        // Halted push: even passes poll the status, odd ones wait on the request
        for (int i = 0; i < 4; i++) begin
            tcf_clr = 1'b1;
            tick(1);
            tcf_clr = 1'b0;
            `CHK(tcf_irq, 1'b0)
            push(csf_pkg::csf_push_t'(24'(rnd())));
            wait_cs(1'b0);
            halt_req = 1'b1;
            transfer_complete_req_enable = i[0];
            tick(1);
            `CHK(txrx_running_status, 1'b1)
            n = 0;
            while (n < 400 && (i[0] ? tcf_irq !== 1'b1 : txrx_running_status !== 1'b0)) begin
                tick(1);
                n++;
            end
            `CHK(cs_n_o, 1'b1)
            if (i[0]) begin
                `CHK(tcf_irq, 1'b1)
                tcf_clr = 1'b1;
                transfer_complete_req_enable = 1'b0;
                tick(35 * 2 * HALF);
                tcf_clr = 1'b0;
            end
            `CHK(txrx_running_status, 1'b0)
            pv = csf_pkg::csf_push_t'(24'(rnd()));
            reply = 16'(rnd());
            push(pv);
            tick(DAT);
            `CHK({cs_n_o, push_ready}, 2'b10)
            halt_req = 1'b0;
            wait_cs(1'b0);
            `CHK({frame_cmd, txrx_running_status}, {pv.cmd, 1'b1})
            wait_cs(1'b1);
            tick(2);
            `CHK({got, rx_data, transfer_complete_flag}, {pv.data, reply, 1'b1})
        end
        // Push swept across the delay tail; only combined mode may corrupt
        for (int m = 0; m < 2; m++) begin
            mode = m ? csf_pkg::CSF_SPI_ONLY : csf_pkg::CSF_COMBINED;
            hits = 0;
            for (int k = 0; k <= DAT + 1; k++) begin
                push(csf_pkg::csf_push_t'(24'(rnd())));
                wait_cs(1'b0);
                wait_cs(1'b1);
                tick(k);
                pv = csf_pkg::csf_push_t'(24'(rnd()));
                push(pv);
                wait_cs(1'b0);
                wait_cs(1'b1);
                tick(2);
                bad = exp_bad(m, k);
                `CHK(corrupt_seen, bad)
                `CHK(bits, exp_bits(bad))
                if (!bad) `CHK(got, pv.data)
                if (corrupt_seen === 1'b1) hits++;
                corrupt_clr = 1'b1;
                tick(DAT + 2);
                corrupt_clr = 1'b0;
            end
            `CHK(hits, m ? 0 : 2)
        end
        mode = csf_pkg::CSF_DSI_ONLY;
        tick(1);
        `CHK(push_ready, 1'b0)
        print_verdict();
    end
    // Watchdog: deserial gap plus every pushed frame, with margin
    initial begin
        tick(DSI_GAP + 24000);
        bad_count++;
        print_verdict();
    end
endmodule : test_combined_serial_frame_control
